// ### nsrd_map.svh
`ifndef NSRD_MAP_SVH
`define NSRD_MAP_SVH
// termination criterion: consecutive non-fast intervals
`define NSRD_TERM_COUNT      3'd5
// least run counter value for a declared run
`define NSRD_MIN_RUN         8'd1
// running mean window length, in intervals
`define NSRD_MEAN_LEN        3'd4
`define NSRD_MEAN_SHIFT      2
// fast/slow boundary in ms
`define NSRD_FAST_LIMIT_MS   12'd220
`define NSRD_MEAN_INIT       12'hFFF
`define NSRD_RATE_INIT       8'h00
`define NSRD_IMP_INIT        16'h0000
`endif

// ### nsrd_pkg.sv
package nsrd_pkg;
  typedef logic [11:0] nsrd_ms_t;
  typedef enum logic [1:0] {
    NSRD_IDLE,
    NSRD_RUN,
    NSRD_HELD
  } nsrd_state_t;
endpackage : nsrd_pkg

// ### nsrd_detector.sv
`timescale 1ns/1ps
`include "nsrd_map.svh"
module nsrd_detector #(
  parameter int CW = 8,
  parameter int TW = 16
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // interval stream from sensing path
  input  wire logic                 interval_valid,
  input  wire nsrd_pkg::nsrd_ms_t   interval_ms,
  input  wire logic                 interval_in_fast_zone,
  input  wire logic [CW-1:0]        detection_count,
  input  wire logic                 full_detection,
  input  wire logic                 episode_end,
  // recording enables and episode classes
  input  wire logic                 run_record_en,
  input  wire logic                 svt_record_en,
  input  wire logic                 af_record_en,
  input  wire logic                 crt_record_en,
  input  wire logic                 supraventricular_episode,
  input  wire logic                 atrial_fibrillation_episode,
  input  wire logic                 resync_pacing_interrupt,
  // time base
  input  wire logic                 day_tick,
  input  wire logic                 minute_tick,
  input  wire logic                 monitor_interval_end,
  input  wire logic                 telemetry_en,
  input  wire logic [7:0]           periodic_days,
  input  wire logic [10:0]          minute_of_day,
  input  wire logic [10:0]          rest_start_min,
  input  wire logic [10:0]          rest_duration_min,
  input  wire logic [7:0]           intrinsic_rate,
  input  wire logic                 intrinsic_rate_valid,
  // impedance
  input  wire logic                 sensed_ventricular,
  input  wire logic [15:0]          impedance_value,
  input  wire logic                 impedance_valid,
  // wave-amplitude test
  input  wire logic                 sensing_test_delay_en,
  input  wire logic [9:0]           permanent_av_delay,
  input  wire logic [9:0]           test_av_delay,
  input  wire logic                 amplitude_test_active,
  // outputs
  output logic                      record_trigger,
  output logic                      run_declared,
  output logic                      run_is_fast,
  output logic [TW-1:0]             run_total,
  output logic [TW-1:0]             run_fast_total,
  output logic [TW-1:0]             run_slow_total,
  output logic [TW-1:0]             trend_fast,
  output logic [TW-1:0]             trend_slow,
  output logic                      trend_valid,
  output logic [7:0]                resting_rate,
  output logic                      resting_rate_valid,
  output logic                      impedance_strobe,
  output logic [15:0]               daily_impedance,
  output logic                      daily_impedance_valid,
  output logic [9:0]                active_av_delay
);
  import nsrd_pkg::*;

  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire rst_n = rst_s2_r;

  nsrd_state_t state_r, state_nxt;
  logic [CW-1:0] run_cnt_r, run_cnt_nxt;
  logic [2:0]    quiet_r, quiet_nxt;
  nsrd_ms_t      win_r [4];
  logic [2:0]    win_fill_r;
  nsrd_ms_t      min_mean_r;
  logic [TW-1:0] tot_r, fast_r, slow_r, mon_fast_r, mon_slow_r;
  logic          other_rec_r;

  // running mean over the last four fast intervals
  wire [13:0] win_sum = {2'b00, win_r[0]} + {2'b00, win_r[1]}
                      + {2'b00, win_r[2]} + {2'b00, interval_ms};
  wire nsrd_ms_t cur_mean = win_sum[13:2];
  wire mean_ok = (win_fill_r >= 3'd3);
  wire take = interval_valid && run_record_en;
  wire fast_iv = take && interval_in_fast_zone;
  wire slow_iv = take && !interval_in_fast_zone;
  // declared run: enough quiet, counter nonzero, below detection
  wire declare = slow_iv && (state_r == NSRD_RUN)
              && (quiet_r == `NSRD_TERM_COUNT - 3'd1)
              && (run_cnt_r >= CW'(`NSRD_MIN_RUN))
              && (run_cnt_r < detection_count);
  wire nsrd_ms_t final_min = (mean_ok && fast_iv && cur_mean < min_mean_r)
                           ? cur_mean : min_mean_r;
  wire declare_fast = (min_mean_r < `NSRD_FAST_LIMIT_MS);

  always_comb begin
    state_nxt   = state_r;
    run_cnt_nxt = run_cnt_r;
    quiet_nxt   = quiet_r;
    case (state_r)
      NSRD_IDLE: begin
        if (fast_iv) begin
          state_nxt   = NSRD_RUN;
          run_cnt_nxt = CW'(1);
          quiet_nxt   = 3'd0;
        end
      end
      NSRD_RUN: begin
        if (fast_iv) begin
          run_cnt_nxt = run_cnt_r + CW'(1);
          quiet_nxt   = 3'd0;
        end else if (declare) begin
          state_nxt   = NSRD_IDLE;
          run_cnt_nxt = '0;
          quiet_nxt   = 3'd0;
        end else if (slow_iv) begin
          quiet_nxt = quiet_r + 3'd1;
          if (quiet_r == `NSRD_TERM_COUNT - 3'd1) begin
            state_nxt   = NSRD_IDLE;
            run_cnt_nxt = '0;
            quiet_nxt   = 3'd0;
          end
        end
      end
      NSRD_HELD: begin
        if (episode_end) state_nxt = NSRD_IDLE;
      end
      default: state_nxt = NSRD_IDLE;
    endcase
    if (full_detection) begin
      state_nxt   = NSRD_HELD;
      run_cnt_nxt = '0;
      quiet_nxt   = 3'd0;
    end
    if (!run_record_en) begin
      state_nxt   = NSRD_IDLE;
      run_cnt_nxt = '0;
      quiet_nxt   = 3'd0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= NSRD_IDLE;
      run_cnt_r <= '0;
      quiet_r   <= 3'd0;
    end else begin
      state_r   <= state_nxt;
      run_cnt_r <= run_cnt_nxt;
      quiet_r   <= quiet_nxt;
    end
  end

  // mean window, reset at run start
  wire run_start = fast_iv && (state_r == NSRD_IDLE) && !full_detection;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      win_r[0]   <= '0;
      win_r[1]   <= '0;
      win_r[2]   <= '0;
      win_r[3]   <= '0;
      win_fill_r <= 3'd0;
      min_mean_r <= `NSRD_MEAN_INIT;
    end else if (run_start) begin
      win_r[0]   <= interval_ms;
      win_fill_r <= 3'd1;
      min_mean_r <= `NSRD_MEAN_INIT;
    end else if (fast_iv && state_r == NSRD_RUN) begin
      win_r[2]   <= win_r[1];
      win_r[1]   <= win_r[0];
      win_r[0]   <= interval_ms;
      win_r[3]   <= cur_mean;
      win_fill_r <= mean_ok ? win_fill_r : win_fill_r + 3'd1;
      min_mean_r <= final_min;
    end
  end

  // run totals, fast/slow split, monitoring interval trend
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tot_r <= '0; fast_r <= '0; slow_r <= '0;
      mon_fast_r <= '0; mon_slow_r <= '0;
      trend_fast <= '0; trend_slow <= '0; trend_valid <= 1'b0;
      record_trigger <= 1'b0; run_declared <= 1'b0; run_is_fast <= 1'b0;
    end else begin
      record_trigger <= declare || other_rec_r;
      run_declared   <= declare;
      trend_valid    <= monitor_interval_end && run_record_en;
      if (declare) begin
        tot_r       <= tot_r + TW'(1);
        run_is_fast <= declare_fast;
        if (declare_fast) fast_r <= fast_r + TW'(1);
        else slow_r <= slow_r + TW'(1);
      end
      if (monitor_interval_end) begin
        trend_fast <= mon_fast_r + TW'(declare && declare_fast);
        trend_slow <= mon_slow_r + TW'(declare && !declare_fast);
        mon_fast_r <= '0;
        mon_slow_r <= '0;
      end else if (declare) begin
        if (declare_fast) mon_fast_r <= mon_fast_r + TW'(1);
        else mon_slow_r <= mon_slow_r + TW'(1);
      end
      if (!run_record_en) begin
        tot_r <= '0; fast_r <= '0; slow_r <= '0;
        mon_fast_r <= '0; mon_slow_r <= '0;
        trend_fast <= '0; trend_slow <= '0;
      end
    end
  end
  assign run_total      = tot_r;
  assign run_fast_total = fast_r;
  assign run_slow_total = slow_r;

  // other episode classes and periodic recording
  logic [7:0] day_cnt_r;
  wire period_hit = day_tick && !telemetry_en && (periodic_days != 8'h00)
                 && (day_cnt_r + 8'd1 >= periodic_days);
  wire class_rec = (supraventricular_episode && svt_record_en)
                || (atrial_fibrillation_episode && af_record_en)
                || (resync_pacing_interrupt && crt_record_en);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      day_cnt_r   <= 8'h00;
      other_rec_r <= 1'b0;
    end else begin
      other_rec_r <= class_rec || period_hit;
      if (telemetry_en || period_hit) day_cnt_r <= 8'h00;
      else if (day_tick) day_cnt_r <= day_cnt_r + 8'd1;
    end
  end

  // resting rate window (minutes, wraps midnight)
  wire [11:0] rest_end = {1'b0, rest_start_min} + {1'b0, rest_duration_min};
  wire [11:0] mod_now  = {1'b0, minute_of_day};
  wire [11:0] mod_late = mod_now + 12'd1440;
  wire in_rest = (mod_now >= {1'b0, rest_start_min} && mod_now < rest_end)
              || (mod_late < rest_end);
  logic [7:0] rest_min_r;
  logic       rest_seen_r, in_rest_q_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rest_min_r <= 8'hFF; rest_seen_r <= 1'b0; in_rest_q_r <= 1'b0;
      resting_rate <= `NSRD_RATE_INIT; resting_rate_valid <= 1'b0;
    end else begin
      in_rest_q_r <= in_rest;
      resting_rate_valid <= 1'b0;
      if (in_rest_q_r && !in_rest) begin
        resting_rate       <= rest_min_r;
        resting_rate_valid <= rest_seen_r;
        rest_min_r  <= 8'hFF;
        rest_seen_r <= 1'b0;
      end else if (in_rest && intrinsic_rate_valid) begin
        rest_seen_r <= 1'b1;
        if (intrinsic_rate < rest_min_r) rest_min_r <= intrinsic_rate;
      end
    end
  end

  // impedance: strobe on sensed beat, daily average
  logic [31:0] imp_sum_r;
  logic [15:0] imp_n_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      impedance_strobe <= 1'b0;
      imp_sum_r <= 32'h0000_0000; imp_n_r <= 16'h0000;
      daily_impedance <= `NSRD_IMP_INIT; daily_impedance_valid <= 1'b0;
    end else begin
      impedance_strobe <= sensed_ventricular;
      if (day_tick) begin
        if (imp_n_r != 16'h0000) begin
          daily_impedance <= 16'(imp_sum_r / {16'h0000, imp_n_r});
          daily_impedance_valid <= 1'b1;
        end
        // a sample on the day boundary opens the new day
        imp_sum_r <= impedance_valid ? {16'h0000, impedance_value} : 32'h0000_0000;
        imp_n_r   <= impedance_valid ? 16'h0001 : 16'h0000;
      end else if (impedance_valid && imp_n_r != 16'hFFFF) begin
        imp_sum_r <= imp_sum_r + {16'h0000, impedance_value};
        imp_n_r   <= imp_n_r + 16'd1;
      end
    end
  end

  // av delay during amplitude test
  wire [9:0] av_sel = (amplitude_test_active && sensing_test_delay_en)
                    ? test_av_delay : permanent_av_delay;
  logic [9:0] av_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) av_r <= 10'h000;
    else av_r <= av_sel;
  end
  assign active_av_delay = av_r;

  wire unused_ok = win_r[3][0];
endmodule : nsrd_detector

// ### nsrd_detector_sva.sv
`timescale 1ns/1ps
module nsrd_detector_sva #(
  parameter int TW = 16
) (
  // stimulus
  input wire logic          core_clk,
  input wire logic          reset_n,
  input wire logic          interval_valid,
  input wire logic          full_detection,
  input wire logic          episode_end,
  input wire logic          run_record_en,
  input wire logic          sensed_ventricular,
  input wire logic          sensing_test_delay_en,
  input wire logic          amplitude_test_active,
  input wire logic [9:0]    permanent_av_delay,
  // results
  input wire logic          record_trigger,
  input wire logic          run_declared,
  input wire logic          run_is_fast,
  input wire logic [TW-1:0] run_total,
  input wire logic [TW-1:0] run_fast_total,
  input wire logic [TW-1:0] run_slow_total,
  input wire logic          impedance_strobe,
  input wire logic [9:0]    active_av_delay
);
  logic held_r;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // open from a full detection until the episode ends
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) held_r <= 1'b0;
    else if (full_detection) held_r <= 1'b1;
    else if (episode_end) held_r <= 1'b0;
  end
  property p_rec; run_declared |-> record_trigger; endproperty
  a_rec: assert property (p_rec) else $error("run without recording");
  property p_tot; run_declared |-> run_total == $past(run_total) + 1'b1; endproperty
  a_tot: assert property (p_tot) else $error("run total step");
  property p_cls;
    run_declared |-> (run_is_fast ? run_fast_total : run_slow_total)
      == (run_is_fast ? $past(run_fast_total) : $past(run_slow_total)) + 1'b1;
  endproperty
  a_cls: assert property (p_cls) else $error("fast or slow total step");
  property p_src; run_declared |-> $past(interval_valid) && $past(run_record_en); endproperty
  a_src: assert property (p_src) else $error("run without interval");
  property p_held; held_r |-> !run_declared; endproperty
  a_held: assert property (p_held) else $error("run during episode");
  property p_off; !run_record_en |=> run_total == '0 && !run_declared; endproperty
  a_off: assert property (p_off) else $error("disabled run counting");
  property p_imp; sensed_ventricular |=> impedance_strobe; endproperty
  a_imp: assert property (p_imp) else $error("impedance strobe missing");
  property p_av;
    amplitude_test_active && !sensing_test_delay_en |=> active_av_delay == $past(permanent_av_delay);
  endproperty
  a_av: assert property (p_av) else $error("av delay in test");
  c_fast: cover property (run_declared && run_is_fast);
  c_slow: cover property (run_declared && !run_is_fast);
  c_held: cover property (held_r && episode_end);
endmodule : nsrd_detector_sva

bind nsrd_detector nsrd_detector_sva #(.TW(TW)) u_sva (.*);

// ### nsrd_sense_model.sv
`timescale 1ns/1ps
module nsrd_sense_model (
  // beat clock
  input wire logic           core_clk,
  // interval stream
  output nsrd_pkg::nsrd_ms_t interval_ms,
  output logic               interval_valid,
  output logic               interval_in_fast_zone
);
  import nsrd_pkg::*;
  logic [12:0] q [$];
  initial begin
    interval_valid = 1'b0;
    interval_ms = 12'h000;
    interval_in_fast_zone = 1'b0;
  end
  // one interval per beat, idle lines toggle
  always @(negedge core_clk) begin
    if (q.size() != 0) begin
      {interval_in_fast_zone, interval_ms} = q.pop_front();
      interval_valid = 1'b1;
    end else begin
      interval_valid = 1'b0;
      interval_in_fast_zone = ~interval_in_fast_zone;
      interval_ms = ~interval_ms;
    end
  end
  task automatic beat(input nsrd_ms_t ms, input logic fz);
    q.push_back({fz, ms});
  endtask : beat
endmodule : nsrd_sense_model

// ### nsrd_detector_tb.sv
`timescale 1ns/1ps
module nsrd_detector_tb;
  import nsrd_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, iv, fz, full_det = 0, ep_end = 0, run_en = 1;
  logic day_tick = 0, min_tick = 0, mon_end = 0, rate_vld = 0, sv = 0, imp_vld = 0;
  logic rec, decl, is_fast, t_vld, rr_vld, imp_stb, di_vld;
  logic [7:0] det = 8'h14, rate = 8'h00, rr, rr_seen = 8'h00;
  logic [8:0] mx = 9'h000;
  logic [9:0] av, perm_av = 10'h0b4, test_av = 10'h064;
  logic [10:0] minute = 11'h000;
  logic [15:0] imp = 16'h0000, tot, f_tot, s_tot, t_fast, t_slow, d_imp, ef = 0, es = 0;
  nsrd_ms_t ms;
  int error_cnt = 0, compares = 0, n_decl = 0, n_rec = 0, cyc = 0;
  always #12.5 core_clk = ~core_clk;
  nsrd_sense_model m (.core_clk, .interval_ms(ms), .interval_valid(iv), .interval_in_fast_zone(fz));
  nsrd_detector uut (
    .core_clk, .reset_n, .interval_valid(iv), .interval_ms(ms), .interval_in_fast_zone(fz),
    .detection_count(det), .full_detection(full_det), .episode_end(ep_end),
    .run_record_en(run_en), .svt_record_en(mx[0]), .af_record_en(mx[1]), .crt_record_en(mx[2]),
    .supraventricular_episode(mx[3]), .atrial_fibrillation_episode(mx[4]),
    .resync_pacing_interrupt(mx[5]), .day_tick, .minute_tick(min_tick),
    .monitor_interval_end(mon_end), .telemetry_en(mx[6]), .periodic_days(8'h07),
    .minute_of_day(minute), .rest_start_min(11'h00a), .rest_duration_min(11'h003),
    .intrinsic_rate(rate), .intrinsic_rate_valid(rate_vld), .sensed_ventricular(sv),
    .impedance_value(imp), .impedance_valid(imp_vld), .sensing_test_delay_en(mx[7]),
    .permanent_av_delay(perm_av), .test_av_delay(test_av), .amplitude_test_active(mx[8]),
    .record_trigger(rec), .run_declared(decl), .run_is_fast(is_fast), .run_total(tot),
    .run_fast_total(f_tot), .run_slow_total(s_tot), .trend_fast(t_fast), .trend_slow(t_slow),
    .trend_valid(t_vld), .resting_rate(rr), .resting_rate_valid(rr_vld),
    .impedance_strobe(imp_stb), .daily_impedance(d_imp), .daily_impedance_valid(di_vld),
    .active_av_delay(av));
  always @(negedge core_clk) begin
    if (decl === 1'b1) n_decl++;
    if (rec === 1'b1) n_rec++;
    if (rr_vld === 1'b1) rr_seen = rr;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %s exp %h got %h", what, exp, got);
      error_cnt++;
    end
  endtask : chk
  task automatic pulse(ref logic s);
    @(negedge core_clk) s = 1'b1;
    @(negedge core_clk) s = 1'b0;
  endtask : pulse
  task automatic run(input int nf, input nsrd_ms_t fms, input int nq);
    for (int i = 0; i < nf; i++) m.beat(fms, 1'b1);
    for (int i = 0; i < nq; i++) m.beat(12'h258, 1'b0);
    while (m.q.size() != 0) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
  endtask : run
  task automatic s_short;
    run(1, 12'h12c, 4);
    chk("early run", 16'h0000, 16'(n_decl));
    run(1, 12'h12c, 5);
    es++;
    chk("run count", 16'h0001, 16'(n_decl));
    chk("short slow", es, s_tot);
  endtask : s_short
  task automatic s_class(input nsrd_ms_t fms, input logic f);
    run(4, fms, 5);
    if (f) ef++;
    else es++;
    chk("fast total", ef, f_tot);
    chk("slow total", es, s_tot);
    chk("run total", ef + es, tot);
    chk("run class", {15'h0000, f}, {15'h0000, is_fast});
  endtask : s_class
  task automatic s_limit;
    det = 8'h03;
    run(2, 12'h12c, 5);
    es++;
    run(3, 12'h12c, 5);
    chk("limit", es, s_tot);
    det = 8'h14;
  endtask : s_limit
  task automatic s_full;
    run(2, 12'h12c, 0);
    pulse(full_det);
    run(1, 12'h12c, 5);
    chk("held", es, s_tot);
    pulse(ep_end);
    run(1, 12'h12c, 5);
    es++;
    chk("after episode", es, s_tot);
  endtask : s_full
  task automatic s_trend;
    pulse(mon_end);
    chk("trend valid", 16'h0001, {15'h0000, t_vld});
    chk("trend fast", ef, t_fast);
    chk("trend slow", es, t_slow);
  endtask : s_trend
  task automatic s_off;
    int n0;
    n0 = n_decl;
    run_en = 1'b0;
    run(1, 12'h12c, 5);
    chk("off total", 16'h0000, tot);
    chk("off runs", 16'(n0), 16'(n_decl));
    run_en = 1'b1;
  endtask : s_off
  task automatic s_imp;
    pulse(sv);
    chk("imp strobe", 16'h0001, {15'h0000, imp_stb});
    imp = 16'h0064;
    pulse(imp_vld);
    imp = 16'h012c;
    pulse(imp_vld);
    pulse(day_tick);
    @(negedge core_clk);
    chk("daily imp", 16'h00c8, d_imp);
    chk("daily valid", 16'h0001, {15'h0000, di_vld});
  endtask : s_imp
  task automatic s_rest;
    logic [7:0] rt [5] = '{8'h28, 8'h46, 8'h3c, 8'h41, 8'h5a};
    for (int i = 0; i < 5; i++) begin
      minute = 11'(9 + i);
      rate = rt[i];
      pulse(min_tick);
      pulse(rate_vld);
    end
    repeat (4) @(negedge core_clk);
    chk("resting rate", 16'h003c, {8'h00, rr_seen});
  endtask : s_rest
  task automatic s_misc;
    mx = 9'h17f;
    repeat (2) @(negedge core_clk);
    chk("av delay", 16'h00b4, {6'h00, av});
    perm_av = 10'h0c8;
    repeat (2) @(negedge core_clk);
    chk("av permanent", 16'h00c8, {6'h00, av});
    mx = 9'h1ff;
    repeat (2) @(negedge core_clk);
    chk("av test", 16'h0064, {6'h00, av});
    mx = 9'h000;
  endtask : s_misc
  task automatic s_rec;
    int n0;
    mx = 9'h008;
    repeat (3) @(negedge core_clk);
    chk("svt no enable", 16'h0000, {15'h0000, rec});
    mx = 9'h009;
    repeat (3) @(negedge core_clk);
    chk("svt recording", 16'h0001, {15'h0000, rec});
    mx = 9'h000;
    repeat (3) @(negedge core_clk);
    n0 = n_rec;
    repeat (6) pulse(day_tick);
    chk("period early", 16'(n0), 16'(n_rec));
    pulse(day_tick);
    repeat (3) @(negedge core_clk);
    chk("period record", 16'(n0 + 1), 16'(n_rec));
    mx = 9'h040;
    n0 = n_rec;
    repeat (7) pulse(day_tick);
    repeat (3) @(negedge core_clk);
    chk("period telemetry", 16'(n0), 16'(n_rec));
    mx = 9'h000;
  endtask : s_rec
  initial begin
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    s_short();
    s_class(12'h0db, 1'b1);
    s_class(12'h0dc, 1'b0);
    s_limit();
    s_full();
    s_trend();
    s_off();
    s_imp();
    s_rest();
    s_misc();
    s_rec();
    end_sim();
  end
endmodule : nsrd_detector_tb
